// >>> core/wdu_pkg.sv
package wdu_pkg;

  // ----------------------------------------------------------------
  // Clock and oscillator rates
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ   = 100_000_000; // System clock rate in Hz.
  localparam int unsigned WDOSC_HZ = 1_000_000;   // Nominal watchdog oscillator rate in Hz.
  localparam int unsigned OSC_DIV  = CLK_HZ / WDOSC_HZ; // System cycles per oscillator tick.

  // ----------------------------------------------------------------
  // Counter and period layout
  // ----------------------------------------------------------------
  localparam int          CNT_W      = 22;           // Watchdog counter width.
  localparam int          PER_W      = 3;            // Period select field width.
  localparam logic [21:0] BASE_TICKS = 22'h004000;   // Shortest period, 16,384 ticks.

  // ----------------------------------------------------------------
  // Register bus and addresses
  // ----------------------------------------------------------------
  localparam int        ADDR_W          = 2;     // Register address width.
  localparam int        DATA_W          = 8;     // Register data width.
  localparam logic [1:0] ADDR_CTRL      = 2'h0;  // Watchdog control register.
  localparam logic [1:0] ADDR_RSTSRC    = 2'h1;  // Reset source status register.
  localparam logic [1:0] ADDR_IRQ_STAT  = 2'h2;  // Interrupt status, cleared by read.
  localparam logic [1:0] ADDR_IRQ_MASK  = 2'h3;  // Interrupt mask.

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_CE_BIT   = 4;  // Change unlock bit.
  localparam int CTRL_EN_BIT   = 3;  // Timer enable bit.
  localparam int CTRL_PER_LSB  = 0;  // Period select field, low bit.
  localparam int CTRL_RES_LSB  = 5;  // Reserved field, low bit.
  localparam int RSTSRC_TO_BIT = 3;  // Timeout reset flag.
  localparam int IRQ_W         = 2;  // Interrupt status width.
  localparam int IRQ_TO_BIT    = 0;  // Timeout event.
  localparam int IRQ_LAPSE_BIT = 1;  // Unlock window ran out unused.
  localparam logic [2:0] CTRL_PER_RST = 3'h0; // Period select after reset.
  localparam logic [1:0] IRQ_MASK_RST = 2'h0; // Interrupt mask after reset.

  // ----------------------------------------------------------------
  // Unlock window length in system cycles
  // ----------------------------------------------------------------
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

endpackage : wdu_pkg

// >>> core/wdu_tick_div.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Divider producing a one-cycle enable at the oscillator rate
// ----------------------------------------------------------------
module wdu_tick_div #(
  parameter int unsigned DIV = 100
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Enable pulse.
  output logic      tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1; // Counter width.

  logic [W-1:0] divCount; // Cycles since the last tick.

  // Count cycles and emit one pulse each DIV cycles.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCount <= '0;
      tick     <= 1'b0;
    end else if (divCount == W'(DIV - 1)) begin
      divCount <= '0;
      tick     <= 1'b1;
    end else begin
      divCount <= divCount + 1'b1;
      tick     <= 1'b0;
    end
  end
endmodule : wdu_tick_div

// >>> core/wdu_watchdog.sv
`timescale 1ns/1ns
// Summary of operation
// - Counter advances on separate 1 MHz oscillator ticks.
// - Restart instruction clears the counter.
// - Disable or any chip reset clears counter.
// - Reaching selected period resets the chip.
// - Period codes select 16K up to 2048K ticks.
// - Control bits 7..5 always read zero.
// - Change unlock bit self-clears after four cycles.
// - Enable sets freely; clearing needs unlock bit.
// - Level one starts disabled, enables without unlock.
// - Level one period or disable needs unlock.
// - Level two always runs, enable reads one.
// - Level two period change needs unlock; enable ignored.
// - Timeout gives one-cycle internal reset pulse.
// - Timeout reset flag set; cleared by writing zero.
module wdu_watchdog
  import wdu_pkg::*;
#(
  parameter int unsigned          DIV   = OSC_DIV,
  parameter logic [CNT_W-1:0]     BASE  = BASE_TICKS
) (
  // Clock and asynchronous power-on reset.
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Register port.
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  // Core events and strap.
  input  wire logic              restartInstr,
  input  wire logic              chipRstIn,
  input  wire logic              safetyFuse,
  // Reset request, status and interrupt.
  output logic                   chipRstOut,
  output logic                   timerRunning,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rstMeta_n;  // First stage, read only by the second stage.
  logic rstSync_n;  // Released reset used everywhere else.

  // Release the asynchronous reset through two flip-flops.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic             tick;          // One-cycle oscillator enable.
  logic             fuseTaken;     // Strap has been sampled.
  logic             levelTwo;      // Safety level two is in force.
  logic             enBit;         // Timer enable bit.
  logic [PER_W-1:0] perSel;        // Period select field.
  logic [2:0]       unlockCnt;     // Cycles left in the unlock window.
  logic             ceBit;         // Change unlock bit as seen.
  logic [CNT_W-1:0] wdCount;       // Watchdog counter.
  logic [CNT_W-1:0] limit;         // Last count before timeout.
  logic             timeout;       // Timeout event this cycle.
  logic             toFlag;        // Timeout reset flag.
  logic [IRQ_W-1:0] irqStat;       // Sticky interrupt status.
  logic [IRQ_W-1:0] irqMask;       // Interrupt mask.
  logic [IRQ_W-1:0] irqSet;        // Events this cycle.
  logic             ctrlWr;        // Write to the control register.
  logic             wCe;           // Written change unlock bit.
  logic             wEn;           // Written enable bit.
  logic [PER_W-1:0] wPer;          // Written period select.
  logic             lapse;         // Unlock window closed unused.
  logic             perLoad;       // Honoured second write loads the period.

  assign ctrlWr = regWr && (regAddr == ADDR_CTRL);
  assign wCe    = regWdata[CTRL_CE_BIT];
  assign wEn    = regWdata[CTRL_EN_BIT];
  assign wPer   = regWdata[CTRL_PER_LSB +: PER_W];
  assign ceBit  = (unlockCnt != 3'h0);
  assign lapse  = (unlockCnt == 3'h1) && !ctrlWr;
  assign perLoad = ctrlWr && ceBit && !(wCe && wEn);

  // The period is the shortest one doubled once per code step.
  assign limit = (BASE << perSel) - 1'b1;

  // ----------------------------------------------------------------
  // Oscillator tick
  // ----------------------------------------------------------------
  // The separate oscillator becomes an enable at its nominal rate.
  wdu_tick_div #(
    .DIV   (DIV)
  ) u_tick (
    .clk   (clk),
    .rst_n (rstSync_n),
    .tick  (tick)
  );

  // ----------------------------------------------------------------
  // Safety level strap
  // ----------------------------------------------------------------
  // Sample the strap once, in the first cycle after release.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      fuseTaken <= 1'b0;
      levelTwo  <= 1'b0;
    end else if (!fuseTaken) begin
      fuseTaken <= 1'b1;
      levelTwo  <= safetyFuse;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Enable, period and the timed unlock window.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      enBit     <= 1'b0;
      perSel    <= CTRL_PER_RST;
      unlockCnt <= 3'h0;
    end else begin
      // The window counts down on its own.
      if (ceBit) begin
        unlockCnt <= unlockCnt - 3'h1;
      end
      if (!fuseTaken) begin
        // Level two comes up already running.
        enBit <= safetyFuse;
      end else if (ctrlWr) begin
        if (wCe && wEn) begin
          // Both bits in one write open the window.
          unlockCnt <= UNLOCK_CYCLES;
          enBit     <= 1'b1;
        end else if (ceBit) begin
          // Second write inside the window is honoured.
          unlockCnt <= 3'h0;
          perSel    <= wPer;
          enBit     <= levelTwo | wEn;
        end else if (wEn) begin
          // Enabling needs no unlock; period is not touched.
          enBit <= 1'b1;
        end
        // A clear of enable or period outside the window is dropped.
      end
      if (levelTwo) begin
        enBit <= 1'b1;
      end
    end
  end

  assign timerRunning = enBit;

  // ----------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------
  assign timeout = enBit && tick && (wdCount == limit)
                   && !restartInstr && !chipRstIn;

  // Count oscillator ticks; clear on restart, disable or reset.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wdCount <= '0;
    end else if (restartInstr) begin
      wdCount <= '0;
    end else if (chipRstIn || !enBit || timeout) begin
      wdCount <= '0;
    end else if (perLoad) begin
      // A new period starts from zero, so a shorter one is never overrun.
      wdCount <= '0;
    end else if (tick) begin
      wdCount <= wdCount + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Reset request and reset source flag
  // ----------------------------------------------------------------
  // One-cycle reset pulse per timeout.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      chipRstOut <= 1'b0;
    end else begin
      chipRstOut <= timeout;
    end
  end

  // Flag set by timeout, cleared by power-on or a written zero.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      toFlag <= 1'b0;
    end else if (timeout) begin
      toFlag <= 1'b1;
    end else if (regWr && regAddr == ADDR_RSTSRC && !regWdata[RSTSRC_TO_BIT]) begin
      toFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    irqSet                = '0;
    irqSet[IRQ_TO_BIT]    = timeout;
    irqSet[IRQ_LAPSE_BIT] = lapse;
  end

  // Sticky status; a read clears it but a new event wins.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      irqStat <= '0;
    end else if (regRd && regAddr == ADDR_IRQ_STAT) begin
      irqStat <= irqSet;
    end else begin
      irqStat <= irqStat | irqSet;
    end
  end

  // Mask register written by software.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      irqMask <= IRQ_MASK_RST;
    end else if (regWr && regAddr == ADDR_IRQ_MASK) begin
      irqMask <= regWdata[IRQ_W-1:0];
    end
  end

  // Level interrupt while any unmasked bit stands.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat & irqMask);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data appear in the cycle after the read strobe only.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      regRdata <= '0;
    end else if (regRd) begin
      regRdata <= '0;
      case (regAddr)
        ADDR_CTRL: begin
          regRdata[CTRL_CE_BIT]              <= ceBit;
          regRdata[CTRL_EN_BIT]              <= enBit;
          regRdata[CTRL_PER_LSB +: PER_W]    <= perSel;
        end
        ADDR_RSTSRC: begin
          regRdata[RSTSRC_TO_BIT] <= toFlag;
        end
        ADDR_IRQ_STAT: begin
          regRdata[IRQ_W-1:0] <= irqStat;
        end
        ADDR_IRQ_MASK: begin
          regRdata[IRQ_W-1:0] <= irqMask;
        end
        default: begin
          regRdata <= '0;
        end
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstSync_n);

  sequence unlockWrite;
    ctrlWr && wCe && wEn && fuseTaken;
  endsequence

  sequence quietFour;
    (!regWr)[*4];
  endsequence

  sequence lateDisable;
    ctrlWr && !wCe && !wEn && !ceBit && enBit && fuseTaken;
  endsequence

  unlock_open_a: assert property (unlockWrite |=> ceBit)
    else $error("Unlock bit not set after unlock write.");

  unlock_close_a: assert property (unlockWrite ##1 quietFour |=> !ceBit)
    else $error("Unlock bit not cleared four cycles after unlock write.");

  late_ignore_a: assert property (lateDisable |=> enBit)
    else $error("Disable outside the unlock window was taken.");

  restart_clear_a: assert property (restartInstr |=> wdCount == '0)
    else $error("Restart did not clear the counter.");

  disable_clear_a: assert property ((!enBit || chipRstIn) |=> wdCount == '0)
    else $error("Counter not cleared while disabled or under chip reset.");

  count_bound_a: assert property (enBit |-> wdCount <= limit)
    else $error("Counter passed the selected period.");

  timeout_fire_a: assert property (timeout |=> chipRstOut ##1 !chipRstOut)
    else $error("Timeout did not give a one-cycle reset pulse.");

  pulse_flag_a: assert property (chipRstOut |-> toFlag && $past(wdCount) == $past(limit))
    else $error("Reset pulse without flag or before the period.");

  level_two_a: assert property (levelTwo |-> enBit && timerRunning)
    else $error("Level two timer not running.");

  reserved_zero_a: assert property ($past(regRd) |-> regRdata[DATA_W-1:CTRL_RES_LSB] == '0)
    else $error("Reserved control bits read nonzero.");

endmodule : wdu_watchdog

// >>> testbench/test_watchdog_timer_with_timed_unlock.sv
`timescale 1ns/1ns
module test_watchdog_timer_with_timed_unlock;
  import wdu_pkg::*;

  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  logic        clk          = 1'b0;  // System clock.
  logic        arst_n       = 1'b0;  // Power-on reset, active low.
  logic [1:0]  regAddr      = 2'h0;  // Register address.
  logic [7:0]  regWdata     = 8'h00; // Register write data.
  logic        regWr        = 1'b0;  // Write strobe.
  logic        regRd        = 1'b0;  // Read strobe.
  logic [7:0]  regRdata;             // Read data.
  logic        restartInstr = 1'b0;  // Restart instruction pulse.
  logic        chipRstIn    = 1'b0;  // Other chip reset source.
  logic        safetyFuse   = 1'b0;  // Safety level strap.
  logic        chipRstOut;           // Timeout reset pulse.
  logic        timerRunning;         // Enable state.
  logic        irq;                  // Interrupt level.
  int          nFail        = 0;     // Mismatches seen.
  int          nTests       = 0;     // Comparisons made.
  int          cycles       = 0;     // Watchdog on the run length.
  int          nPulse       = 0;     // Timeout pulses seen.
  int          n;                    // Cycle count of one wait.
  logic [7:0]  rowAddr [5]  = '{8'h3, 8'h3, 8'h0, 8'h1, 8'h0};    // Row address.
  logic [7:0]  rowData [5]  = '{8'h03, 8'h00, 8'he0, 8'h00, 8'h07}; // Row write data.
  logic [7:0]  rowExp  [5]  = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00}; // Row read back.

  // Short counts keep the run brief: 2 clocks per tick, 4 ticks base.
  localparam int unsigned SIM_DIV  = 2;
  localparam int unsigned SIM_BASE = 4;

  always #5 clk = ~clk;

  wdu_watchdog #(.DIV(SIM_DIV), .BASE(22'(SIM_BASE))) u_dut (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .restartInstr(restartInstr), .chipRstIn(chipRstIn),
    .safetyFuse(safetyFuse), .chipRstOut(chipRstOut), .timerRunning(timerRunning), .irq(irq));

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  // Counts timeout pulses and cuts a hung run short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (chipRstOut === 1'b1) begin
      nPulse <= nPulse + 1;
    end
    if (cycles == 20000) begin
      nFail = nFail + 1;
      testDone();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Ends the run with the verdict.
  task automatic testDone();
    if (nFail == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : testDone

  // Compares one byte.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    nTests = nTests + 1;
    if (got !== exp) begin
      nFail = nFail + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  // Compares one flag.
  task automatic chk1(input logic got, input logic exp);
    nTests = nTests + 1;
    if (got !== exp) begin
      nFail = nFail + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  // One-cycle register write.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : wr

  // One-cycle register read; data are checked in the following cycle.
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 chk8(regRdata, exp);
  endtask : rd

  // Restart instruction, one cycle.
  task automatic kick();
    @(posedge clk);
    restartInstr <= 1'b1;
    @(posedge clk);
    restartInstr <= 1'b0;
  endtask : kick

  // Reset with the given safety level strap.
  task automatic doReset(input logic fuse);
    @(posedge clk);
    arst_n     <= 1'b0;
    safetyFuse <= fuse;
    repeat (2) @(posedge clk);
    arst_n     <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : doReset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    doReset(1'b0);
    chk1(timerRunning, 1'b0);
    rd(2'h0, 8'h00);
    // Plain register rows with the timer stopped.
    for (int i = 0; i < 5; i++) begin
      wr(rowAddr[i][1:0], rowData[i]);
      rd(rowAddr[i][1:0], rowExp[i]);
    end
    // Enable freely, refuse a plain disable, then the unlocked disable.
    wr(2'h0, 8'h08);
    #1 chk1(timerRunning, 1'b1);
    wr(2'h0, 8'h00);
    #1 chk1(timerRunning, 1'b1);
    wr(2'h0, 8'h18);
    wr(2'h0, 8'h00);
    #1 chk1(timerRunning, 1'b0);
    // Unlocked period change; the unlock bit is seen while open.
    wr(2'h0, 8'h18);
    wr(2'h0, 8'h0f);
    rd(2'h0, 8'h0f);
    kick();
    wr(2'h0, 8'h18);
    rd(2'h0, 8'h1f);
    repeat (5) @(posedge clk);
    rd(2'h0, 8'h0f);
    rd(2'h2, 8'h02);
    wr(2'h0, 8'h07);
    rd(2'h0, 8'h0f);
    // Restarts well inside the period hold off any timeout.
    n = nPulse;
    repeat (3) begin
      kick();
      repeat (500) @(posedge clk);
    end
    chk1(nPulse == n, 1'b1);
    // Timeout length for every period code, with a one-cycle pulse.
    wr(2'h3, 8'h01);
    for (int p = 0; p < 8; p++) begin
      wr(2'h0, 8'h18);
      wr(2'h0, 8'h08 | 8'(p));
      kick();
      n = 0;
      do begin
        @(posedge clk);
        #1 n++;
      end while (chipRstOut !== 1'b1 && n < 5000);
      chk1(n >= (SIM_BASE << p) * SIM_DIV - 4 && n <= (SIM_BASE << p) * SIM_DIV + 4, 1'b1);
      @(posedge clk);
      #1 chk1(chipRstOut, 1'b0);
      chk1(irq, 1'b1);
    end
    rd(2'h1, 8'h08);
    // Stop the timer, then clear the flag and the sticky status.
    wr(2'h0, 8'h18);
    wr(2'h0, 8'h00);
    rd(2'h2, 8'h01);
    rd(2'h2, 8'h00);
    wr(2'h1, 8'h00);
    rd(2'h1, 8'h00);
    #1 chk1(irq, 1'b0);
    // Another reset source holds the counter clear.
    wr(2'h0, 8'h08);
    @(posedge clk);
    chipRstIn <= 1'b1;
    n = nPulse;
    repeat (40) @(posedge clk);
    chk1(nPulse == n, 1'b1);
    chipRstIn <= 1'b0;
    repeat (20) @(posedge clk);
    chk1(nPulse > n, 1'b1);
    // Safety level two: always running, enable ignored on change.
    doReset(1'b1);
    chk1(timerRunning, 1'b1);
    rd(2'h0, 8'h08);
    wr(2'h0, 8'h18);
    wr(2'h0, 8'h02);
    rd(2'h0, 8'h0a);
    chk1(timerRunning, 1'b1);
    // Window end points: the fourth cycle is honoured, the fifth is not.
    wr(2'h0, 8'h18);
    repeat (2) @(posedge clk);
    wr(2'h0, 8'h0b);
    rd(2'h0, 8'h0b);
    wr(2'h0, 8'h18);
    repeat (3) @(posedge clk);
    wr(2'h0, 8'h01);
    rd(2'h0, 8'h0b);
    testDone();
  end

endmodule : test_watchdog_timer_with_timed_unlock
